// ### src/spi_port.sv
// Byte-wide serial port, master or slave, with AHB-Lite registers
`timescale 1ns/100ps

// Overview of operation
// RQ1: Slave select is input in slave mode; low activates, MISO driven if enabled.
// RQ2: Slave select high makes slave passive and drops any partial byte at once.
// RQ3: Master with select as output: pin is plain output, no effect on port.
// RQ4: Master with select input low: demote to slave, inputs, set done flag.
// RQ5: Outside master keeps select high; software re-sets master bit after fault.
// RQ6: Interrupt requested when enable bit, done flag and global enable set.
// RQ7: Port enable bit zero forbids every transfer and port action.
// RQ8: Bit order bit one sends LSB first, zero sends MSB first.
// RQ9: Master select bit one chooses master, zero chooses slave.
// RQ10: Polarity bit sets SCK idle level and so the leading edge direction.
// RQ11: Phase zero samples leading, changes trailing; phase one the reverse.
// RQ12: Master SCK divisor from rate bits and double bit; slave ignores rate.
// RQ13: Done flag sets at transfer end; cleared by vector or status-then-data.
// RQ14: Data write during transfer sets collision; status-then-data clears both.
// RQ15: Status bits five to one always read zero.
// RQ16: Double bit doubles master SCK, shortest period two system clocks.
// RQ17: Data write loads shifter and starts; data read returns receive buffer.
// RQ18: Polarity and phase form modes 0 to 3; change opposite sample edge.
// RQ19: Master stops SCK after eight bits and sets done flag.
// RQ20: Receive buffered once; unread byte overwritten by next completion.
// RQ21: Colliding data write leaves the byte in flight untouched.
module spi_port
    import spi_port_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Serial pins
    input  wire spi_pins_t   pin_in,
    output spi_pins_t        pin_out,
    output spi_pins_t        pin_oe,
    // Pin direction settings from the port logic
    input  wire logic        sck_dir_out,
    input  wire logic        mosi_dir_out,
    input  wire logic        miso_dir_out,
    input  wire logic        ss_dir_out,
    input  wire logic        ss_gpio_level,
    // CPU interrupt interface
    input  wire logic        global_irq_enable,
    input  wire logic        irq_vector_taken,
    output logic             xfer_irq
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [6:0] half_period(input logic dbl, input logic [1:0] rate);
        logic [7:0] div;
        div = 8'h00;
        unique case ({dbl, rate})
            3'b000:  div = DIV_NORM_0;
            3'b001:  div = DIV_NORM_1;
            3'b010:  div = DIV_NORM_2;
            3'b011:  div = DIV_NORM_3;
            3'b100:  div = DIV_DBL_0;
            3'b101:  div = DIV_DBL_1;
            3'b110:  div = DIV_DBL_2;
            3'b111:  div = DIV_DBL_3;
        endcase
        return div[7:1];
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic b,
                                            input logic lsb);
        return lsb ? {b, sr[7:1]} : {sr[6:0], b};
    endfunction

    port_state_t st;
    port_state_t next_st;
    logic        addr_take;
    logic        rd_take;
    logic        wr_now;
    logic        data_access;
    logic        in_xfer;
    logic        en;
    logic        tick;
    logic        edge_ok;
    logic        sample;
    logic        last;
    logic        in_bit;
    logic        fault;
    logic        set_done;
    logic        set_write_collision_flag;
    logic        out_bit;

    assign en      = st.ctrl.port_enable;
    assign in_xfer = st.ctrl.master_select ? (st.xs == ST_SHIFT) : (st.edge_cnt != 4'h0);
    assign out_bit = st.ctrl.bit_order_lsb_first ? st.sr[0] : st.sr[7]; // RQ8

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        next_st     = st;
        tick        = 1'b0;
        edge_ok     = 1'b0;
        sample      = 1'b0;
        last        = 1'b0;
        in_bit      = 1'b0;
        fault       = 1'b0;
        set_done    = 1'b0;
        set_write_collision_flag    = 1'b0;

        // Pin synchronisers
        next_st.sync1    = pin_in;
        next_st.sync2    = st.sync1;
        next_st.sck_prev = st.sync2.sck;

        // Bus address phase
        addr_take        = hsel && htrans[1] && hready;
        rd_take          = addr_take && !hwrite;
        wr_now           = st.ap_valid && st.ap_write;
        next_st.ap_valid = addr_take;
        next_st.ap_write = hwrite;
        next_st.ap_addr  = haddr[7:0];
        data_access      = (rd_take && haddr[7:0] == DATA_OFFSET)
                        || (wr_now && st.ap_addr == DATA_OFFSET);

        if (rd_take)
        begin
            unique case (haddr[7:0])
                CTRL_OFFSET:   next_st.hrdata = {24'h000000, st.ctrl};
                STATUS_OFFSET: next_st.hrdata = {24'h000000, st.done, st.write_collision_flag, 5'h00,
                                                 st.double_rate}; // RQ15
                DATA_OFFSET:   next_st.hrdata = {24'h000000, st.rx_buf}; // RQ17
                default:       next_st.hrdata = 32'h00000000;
            endcase
        end

        // Flag clearing: status read arms, data access clears
        if (data_access)
        begin
            if (st.arm_done || st.arm_write_collision_flag)
            begin
                next_st.done = 1'b0; // RQ13
            end
            if (st.arm_write_collision_flag)
            begin
                next_st.write_collision_flag = 1'b0; // RQ14
            end
            next_st.arm_done = 1'b0;
            next_st.arm_write_collision_flag = 1'b0;
        end
        if (rd_take && haddr[7:0] == STATUS_OFFSET)
        begin
            next_st.arm_done = st.done;
            next_st.arm_write_collision_flag = st.write_collision_flag;
        end
        if (irq_vector_taken)
        begin
            next_st.done = 1'b0; // RQ13
        end

        // Register writes
        if (wr_now)
        begin
            unique case (st.ap_addr)
                CTRL_OFFSET:   next_st.ctrl = hwdata[7:0]; // RQ9
                STATUS_OFFSET: next_st.double_rate = hwdata[STAT_DOUBLE_BIT]; // RQ16
                DATA_OFFSET:
                begin
                    if (in_xfer)
                    begin
                        set_write_collision_flag = 1'b1; // RQ14 RQ21
                    end
                    else
                    begin
                        next_st.sr       = hwdata[7:0]; // RQ17
                        next_st.edge_cnt = 4'h0;
                        if (st.ctrl.master_select && en)
                        begin
                            next_st.xs      = ST_SHIFT;
                            next_st.div_cnt = 7'h00;
                        end
                    end
                end
                default: ;
            endcase
        end

        // Edge source: divider in master, sampled pin in slave
        if (st.ctrl.master_select)
        begin
            if (st.xs == ST_SHIFT)
            begin
                if (st.div_cnt == half_period(st.double_rate,
                                              {st.ctrl.rate_sel_hi, st.ctrl.rate_sel_lo}) - 7'h01)
                begin
                    tick            = 1'b1; // RQ12 RQ16
                    next_st.div_cnt = 7'h00;
                    next_st.sck_q   = ~st.sck_q;
                end
                else
                begin
                    next_st.div_cnt = st.div_cnt + 7'h01;
                end
            end
            edge_ok = tick;
            in_bit  = st.sync2.miso;
        end
        else
        begin
            edge_ok = en && !st.sync2.ss_n && (st.sync2.sck != st.sck_prev); // RQ1
            in_bit  = st.sync2.mosi;
        end

        // Shift engine; even edge count is the leading edge
        if (edge_ok && en)
        begin
            sample = st.edge_cnt[0] ^ ~st.ctrl.cpha; // RQ11 RQ18
            last   = st.edge_cnt == LAST_EDGE;
            if (sample)
            begin
                next_st.samp = in_bit;
            end
            else if (!(st.ctrl.cpha && st.edge_cnt == 4'h0))
            begin
                next_st.sr = shift_in(st.sr, st.samp, st.ctrl.bit_order_lsb_first);
            end
            next_st.edge_cnt = st.edge_cnt + 4'h1;
            if (last)
            begin
                // Phase one ends on a sample edge: line held, last bit folded in here
                next_st.rx_buf = st.ctrl.cpha
                               ? shift_in(st.sr, in_bit, st.ctrl.bit_order_lsb_first)
                               : next_st.sr; // RQ18 RQ20
                next_st.xs     = ST_IDLE; // RQ19
                set_done       = 1'b1; // RQ19
            end
        end

        // Slave select high resets the slave edge count
        if (!st.ctrl.master_select && st.sync2.ss_n)
        begin
            next_st.edge_cnt = 4'h0; // RQ2
        end

        // Mode fault: select pin pulled low while master
        if (en && st.ctrl.master_select && !ss_dir_out && !st.sync2.ss_n)
        begin
            fault                       = 1'b1;
            next_st.ctrl.master_select  = 1'b0; // RQ4
            next_st.xs                  = ST_IDLE;
            next_st.edge_cnt            = 4'h0;
            set_done                    = 1'b1; // RQ4
        end

        if (!next_st.ctrl.port_enable)
        begin
            next_st.xs       = ST_IDLE; // RQ7
            next_st.edge_cnt = 4'h0;
        end
        if (next_st.xs == ST_IDLE)
        begin
            next_st.sck_q = next_st.ctrl.cpol; // RQ10
        end

        // Sets win over clears
        if (set_done)
        begin
            next_st.done = 1'b1;
        end
        if (set_write_collision_flag)
        begin
            next_st.write_collision_flag = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st <= '0;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata       = st.hrdata;
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign xfer_irq     = st.ctrl.xfer_irq_enable && st.done && global_irq_enable; // RQ6
    assign pin_out.sck  = st.sck_q;
    assign pin_out.mosi = out_bit;
    assign pin_out.miso = out_bit;
    assign pin_out.ss_n = ss_gpio_level; // RQ3
    assign pin_oe.sck   = en && st.ctrl.master_select && sck_dir_out; // RQ4
    assign pin_oe.mosi  = en && st.ctrl.master_select && mosi_dir_out; // RQ4
    assign pin_oe.miso  = en && !st.ctrl.master_select && !st.sync2.ss_n && miso_dir_out; // RQ1
    assign pin_oe.ss_n  = ss_dir_out && (!en || st.ctrl.master_select); // RQ1 RQ3

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_last_edge;
        st.xs == ST_SHIFT && tick && st.edge_cnt == LAST_EDGE && ce && !fault;
    endsequence

    sequence s_finish;
        st.xs == ST_IDLE && st.done;
    endsequence

    a_reserved_zero: assert property (rd_take && haddr[7:0] == STATUS_OFFSET && ce
        |=> hrdata[5:1] == 5'h00) else $error("reserved status bits not zero"); // RQ15

    a_fault_demote: assert property (fault && ce
        |=> !st.ctrl.master_select && st.done && !pin_oe.sck) else $error("no demotion"); // RQ4

    a_slave_ss_reset: assert property (!st.ctrl.master_select && st.sync2.ss_n && ce
        |=> st.edge_cnt == 4'h0) else $error("slave not reset by select"); // RQ2

    a_disabled_idle: assert property (!next_st.ctrl.port_enable && ce
        |=> st.xs == ST_IDLE && !pin_oe.mosi && !pin_oe.miso) else $error("active off"); // RQ7

    a_write_collision_flag_set: assert property (wr_now && st.ap_addr == DATA_OFFSET && in_xfer && ce
        |=> st.write_collision_flag) else $error("collision flag not set"); // RQ14

    a_write_collision_flag_keep: assert property (wr_now && st.ap_addr == DATA_OFFSET && in_xfer && ce
        && st.edge_cnt != LAST_EDGE && !fault && en
        |=> st.edge_cnt >= $past(st.edge_cnt)) else $error("transfer restarted"); // RQ21

    a_sample_hold: assert property (edge_ok && en && sample && !wr_now && ce
        |=> $stable(out_bit)) else $error("data line moved on a sample edge"); // RQ18

    a_irq_request: assert property (st.done && st.ctrl.xfer_irq_enable && global_irq_enable
        |-> xfer_irq) else $error("interrupt not requested"); // RQ6

    a_sck_idle: assert property (st.xs == ST_IDLE && $past(st.xs) == ST_IDLE && $past(ce)
        && $stable(st.ctrl.cpol) |-> pin_out.sck == st.ctrl.cpol) else $error("bad idle"); // RQ10

    a_master_stop: assert property (s_last_edge |=> s_finish)
        else $error("master did not stop after byte"); // RQ19

    a_status_clear: assert property (data_access && st.arm_done && !set_done
        && !irq_vector_taken && ce |=> !st.done) else $error("done flag not cleared"); // RQ13

endmodule // spi_port

// ### src/spi_port_pkg.sv
// Constants and carrier types of the serial port
package spi_port_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] DATA_OFFSET   = 8'h08;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] STATUS_RESET  = 8'h00;
    localparam logic [7:0] DATA_RESET    = 8'h00;

    // ------------------------------------------------------------
    // Status field positions
    // ------------------------------------------------------------
    localparam int STAT_DONE_BIT   = 7;
    localparam int STAT_WRITE_COLLISION_FLAG_BIT   = 6;
    localparam int STAT_DOUBLE_BIT = 0;

    // ------------------------------------------------------------
    // Clock divisors and transfer length
    // ------------------------------------------------------------
    localparam logic [7:0] DIV_NORM_0 = 8'h04;
    localparam logic [7:0] DIV_NORM_1 = 8'h10;
    localparam logic [7:0] DIV_NORM_2 = 8'h40;
    localparam logic [7:0] DIV_NORM_3 = 8'h80;
    localparam logic [7:0] DIV_DBL_0  = 8'h02;
    localparam logic [7:0] DIV_DBL_1  = 8'h08;
    localparam logic [7:0] DIV_DBL_2  = 8'h20;
    localparam logic [7:0] DIV_DBL_3  = 8'h40;
    localparam logic [3:0] LAST_EDGE  = 4'hf;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } spi_pins_t;

    typedef enum logic {
        ST_IDLE  = 1'b0,
        ST_SHIFT = 1'b1
    } xfer_state_t;

    typedef struct packed {
        logic xfer_irq_enable;
        logic port_enable;
        logic bit_order_lsb_first;
        logic master_select;
        logic cpol;
        logic cpha;
        logic rate_sel_hi;
        logic rate_sel_lo;
    } port_ctrl_t;

    typedef struct packed {
        port_ctrl_t  ctrl;
        logic        double_rate;
        logic        done;
        logic        write_collision_flag;
        logic        arm_done;
        logic        arm_write_collision_flag;
        logic [7:0]  sr;
        logic [7:0]  rx_buf;
        logic        samp;
        logic [3:0]  edge_cnt;
        logic [6:0]  div_cnt;
        xfer_state_t xs;
        logic        sck_q;
        spi_pins_t   sync1;
        spi_pins_t   sync2;
        logic        sck_prev;
        logic        ap_valid;
        logic        ap_write;
        logic [7:0]  ap_addr;
        logic [31:0] hrdata;
    } port_state_t;

endpackage

// ### dv/spi_slave_model.sv
// Behavioural serial slave facing the port in master mode
`timescale 1ns/100ps
module spi_slave_model (
    // Serial pins
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       ss_n,
    output logic            miso,
    // Format and data
    input  wire logic       cpha,
    input  wire logic       lsb,
    input  wire logic [7:0] tx,
    output logic      [7:0] rx
);
    int   k;
    logic ss_seen = 1'b1;

    function automatic logic pick(input int j);
        return lsb ? tx[j] : tx[7 - j];
    endfunction

    // Select low: first bit ready before the leading edge
    // Select high: released line has no pull, show the opposite level
    always @(ss_n or sck)
    begin
        if (ss_n !== ss_seen)
        begin
            ss_seen = ss_n;
            k = 0;
            miso = ss_n ? ~miso : pick(0);
        end
        else if (!ss_n)
        begin
            if ((k % 2 == 1) == cpha)
                rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
            else if ((cpha ? k / 2 : (k + 1) / 2) < 8)
                miso = pick(cpha ? k / 2 : (k + 1) / 2);
            else
                miso = ~miso;
            k = k + 1;
        end
    end
endmodule // spi_slave_model

// ### dv/tb.sv
// Self-checking bench of the serial port
`timescale 1ns/100ps
module tb;
    import spi_port_pkg::*;

    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, xfer_irq;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic        bsck, bmosi, bss, bmode, gie, ivt, ss_dir, ss_lvl, cph, lsb, psck;
    logic        sck_w, mosi_w, miso_w, ss_w, mmiso;
    logic [7:0]  stx, srx, tbyte, r8, ctl;
    spi_pins_t   pin_out, pin_oe, pin_w;
    int          cyc = 0;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          q_t[$];
    int          dv[8] = '{4, 16, 64, 128, 2, 8, 32, 64};

    assign sck_w  = pin_oe.sck ? pin_out.sck : bsck;
    assign mosi_w = pin_oe.mosi ? pin_out.mosi : bmosi;
    assign miso_w = pin_oe.miso ? pin_out.miso : mmiso;
    assign ss_w   = pin_oe.ss_n ? pin_out.ss_n : bss;
    assign pin_w  = {sck_w, mosi_w, miso_w, ss_w};

    spi_port spi_port_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pin_in(pin_w), .pin_out(pin_out), .pin_oe(pin_oe),
        .sck_dir_out(1'b1), .mosi_dir_out(1'b1), .miso_dir_out(1'b1),
        .ss_dir_out(ss_dir), .ss_gpio_level(ss_lvl), .global_irq_enable(gie),
        .irq_vector_taken(ivt), .xfer_irq(xfer_irq));

    spi_slave_model spi_slave_model_i (.sck(sck_w), .mosi(mosi_w), .ss_n(ss_w | bmode),
        .miso(mmiso), .cpha(cph), .lsb(lsb), .tx(stx), .rx(srx));

    // ------------------------------------------------------------
    // Clock, edge log, timeout
    // ------------------------------------------------------------
    initial
    begin
        hclk = 0;
        forever #25 hclk = ~hclk;
    end

    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        psck <= sck_w;
        if (sck_w !== psck) q_t.push_back(cyc);
        if (cyc == 40000)
        begin
            n_mismatch++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd_v);
        hsel <= 1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_v = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        bus(1'b0, a, 32'h0, v);
    endtask

    // External master drives n bits of mode 0, sampling the port's reply
    task automatic sbyte(input logic [7:0] mb, input int n, output logic [7:0] got);
        for (int j = 0; j < n; j++)
        begin
            bmosi <= mb[7 - j];
            repeat (4) @(posedge hclk);
            got = {got[6:0], miso_w};
            bsck <= 1;
            repeat (4) @(posedge hclk);
            bsck <= 0;
        end
        repeat (4) @(posedge hclk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        hresetn = 0; hsel = 0; htrans = 0; haddr = 0; hwrite = 0; hwdata = 0;
        bsck = 0; bmosi = 0; bss = 1; bmode = 0; gie = 1; ivt = 0;
        ss_dir = 1; ss_lvl = 1; cph = 0; lsb = 0; stx = 0;
        void'($urandom(83534));
        repeat (5) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        for (int a = 0; a < 16; a += 4)
        begin
            rd(a[7:0], r);
            chk(r, 32'h0);
        end
        wr(8'h0c, 32'hff);
        rd(8'h0c, r);
        chk(r, 32'h0);
        wr(STATUS_OFFSET, 32'hff);
        rd(STATUS_OFFSET, r);
        chk(r, 32'h1);
        // Master transfers over every mode, order and rate
        for (int i = 0; i < 8; i++)
        begin
            ctl = {i[0], 1'b1, i[2], 1'b1, i[1:0], i[1:0]};
            cph = i[0];
            lsb = i[2];
            gie <= (i != 3);
            tbyte = 8'($urandom);
            stx = 8'($urandom);
            wr(STATUS_OFFSET, {31'h0, i[2]});
            wr(CTRL_OFFSET, {24'h0, ctl});
            repeat (3) @(posedge hclk);
            chk(sck_w, i[1]);
            q_t.delete();
            ss_lvl <= 0;
            wr(DATA_OFFSET, {24'h0, tbyte});
            if (i == 1)
            begin
                repeat (6) @(posedge hclk);
                wr(DATA_OFFSET, {24'h0, ~tbyte});
                rd(STATUS_OFFSET, r);
                chk(r, 32'h40);
            end
            do rd(STATUS_OFFSET, r); while (r[7] !== 1'b1);
            chk(r, {24'h0, 1'b1, i == 1, 5'h0, i[2]});
            chk(xfer_irq, i[0] && gie);
            chk(q_t.size(), 16);
            chk(q_t[1] - q_t[0], dv[i] / 2);
            chk(srx, tbyte);
            chk(sck_w, i[1]);
            rd(DATA_OFFSET, r);
            if (dv[i] >= 8) chk(r, {24'h0, stx});
            rd(STATUS_OFFSET, r);
            chk(r, {31'h0, i[2]});
            rd(CTRL_OFFSET, r);
            chk(r, {24'h0, ctl});
            ss_lvl <= 1;
        end
        wr(STATUS_OFFSET, 32'h0);
        // Select pulled low while master with select as input
        ss_dir <= 0;
        wr(CTRL_OFFSET, 32'h50);
        bss <= 0;
        repeat (6) @(posedge hclk);
        rd(CTRL_OFFSET, r);
        chk(r, 32'h40);
        rd(STATUS_OFFSET, r);
        chk(r, 32'h80);
        chk(pin_oe.sck, 1'b0);
        ivt <= 1;
        @(posedge hclk);
        ivt <= 0;
        rd(STATUS_OFFSET, r);
        chk(r, 32'h0);
        bss <= 1;
        wr(CTRL_OFFSET, 32'h50);
        repeat (4) @(posedge hclk);
        rd(CTRL_OFFSET, r);
        chk(r, 32'h50);
        // Disabled port must not shift
        ss_dir <= 1;
        wr(CTRL_OFFSET, 32'h10);
        q_t.delete();
        wr(DATA_OFFSET, 32'ha5);
        repeat (40) @(posedge hclk);
        chk(q_t.size(), 0);
        rd(STATUS_OFFSET, r);
        chk(r, 32'h0);
        // Slave: aborted partial byte, then a full one
        bmode <= 1;
        wr(CTRL_OFFSET, 32'h40);
        wr(DATA_OFFSET, 32'h3c);
        chk(pin_oe.miso, 1'b0);
        bss <= 0;
        sbyte(8'hff, 3, r8);
        bss <= 1;
        repeat (4) @(posedge hclk);
        chk(pin_oe.miso, 1'b0);
        tbyte = 8'($urandom);
        stx = 8'($urandom);
        wr(DATA_OFFSET, {24'h0, stx});
        bss <= 0;
        repeat (4) @(posedge hclk);
        chk(pin_oe.miso, 1'b1);
        sbyte(tbyte, 8, r8);
        bss <= 1;
        chk(r8, stx);
        rd(STATUS_OFFSET, r);
        chk(r, 32'h80);
        rd(DATA_OFFSET, r);
        chk(r, {24'h0, tbyte});
        close_out();
    end
endmodule // tb
